// [logic/otc_defs.vh]
// Constants for the output tie-off and thermal control block
`ifndef OTC_DEFS_VH
`define OTC_DEFS_VH

`define OTC_AW 7
`define OTC_DW 9

// Register offsets
`define OTC_ADDR_TIEOFF 7'h31
`define OTC_ADDR_OUTEN 7'h40
`define OTC_ADDR_BOOST 7'h41
`define OTC_ADDR_SWITCH 7'h42
`define OTC_ADDR_IRQ_STATUS 7'h43
`define OTC_ADDR_IRQ_MASK 7'h44
`define OTC_ADDR_STATE 7'h45

// Tie-off register fields
`define OTC_F_RES_SEL 0
`define OTC_F_TSD_EN 1
`define OTC_TIEOFF_RESET 9'h002

// Output enable register fields
`define OTC_F_SPKP_EN 0
`define OTC_F_SPKN_EN 1
`define OTC_F_MONO_EN 2
`define OTC_F_BUF_EN 3
`define OTC_F_MONO_MUTE 4
`define OTC_OUTEN_RESET 9'h000

// Level shift register fields
`define OTC_F_SPK_BOOST 0
`define OTC_F_MONO_BOOST 1
`define OTC_BOOST_RESET 9'h000

// Switch register fields
`define OTC_F_PINSEL_LO 0
`define OTC_PINSEL_W 3
`define OTC_F_SW_POL 3
`define OTC_F_SLOW_EN 4
`define OTC_F_TWO_WIRE 5
`define OTC_SWITCH_RESET 9'h000
`define OTC_PINSEL_SWITCH 3'h1

// Interrupt bits
`define OTC_I_TSD 0
`define OTC_I_SWITCH 1
`define OTC_IRQ_W 2
`define OTC_IRQ_RESET 2'h0

// Slow tick period in master clock periods, as log2
`define OTC_SLOW_LOG2 21

`endif

// [logic/otc_slow_tick.v]
// Gated divider producing a one-cycle slow tick every 2**LOG2 clocks while enabled
`timescale 1ns/10ps
`default_nettype none
`include "otc_defs.vh"
module otc_slow_tick #(
    parameter LOG2 = `OTC_SLOW_LOG2
) (
    input wire clock,
    input wire resetn,
    input wire enable,
    output wire tick
);
    reg [LOG2-1:0] count_q;

    // Held at zero while disabled so the first period after enable is whole
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_q <= {LOG2{1'b0}};
        end else if (!enable) begin
            count_q <= {LOG2{1'b0}};
        end else begin
            count_q <= count_q + {{(LOG2-1){1'b0}}, 1'b1};
        end
    end

    assign tick = enable && (&count_q);
endmodule
`default_nettype wire

// [logic/otc_debounce.v]
// Two-sample debouncer for the switch level, advanced on slow ticks
`timescale 1ns/10ps
`default_nettype none
module otc_debounce (
    input wire clock,
    input wire resetn,
    input wire tick,
    input wire level,
    output wire stable,
    output wire changed
);
    reg sample_q;
    reg stable_q;

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sample_q <= 1'b0;
            stable_q <= 1'b0;
        end else if (tick) begin
            sample_q <= level;
            if (sample_q == level) begin
                stable_q <= level; // see RQ15
            end
        end
    end

    assign stable = stable_q;
    assign changed = tick && (sample_q == level) && (stable_q != level);
endmodule
`default_nettype wire

// [logic/otc_top.v]
// Output tie-off, output switch and thermal shutdown control
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "otc_defs.vh"

// Contract
// RQ1 - Disabled output uses high resistance when select bit is 1, else low.
// RQ2 - Resistance select bit resets to 0, the low resistance.
// RQ3 - Disabled output with boost set ties to 1.5xAVDD/2, else AVDD/2.
// RQ4 - Enabled output DC level follows its boost bit, resistance ignored.
// RQ5 - Unused-pin tie-off buffer is powered only while its enable is set.
// RQ6 - Switch mode needs 2-wire control and pin function select 001.
// RQ7 - High switch enables speaker only, low enables mono only, per enables.
// RQ8 - Polarity bit inverts the switch input before selection.
// RQ9 - Software sets speaker and mono enables before relying on the switch.
// RQ10 - Debounce on slow tick every 2^21 clocks, only when enabled.
// RQ11 - Over-temperature with shutdown enabled disables speaker amplifiers.
// RQ12 - Thermal shutdown enable resets to 1.
// RQ13 - Thermal shutdown event can raise an interrupt.
// RQ14 - Mono mute makes mono a DC driver at speaker DC offset.
// RQ15 - New switch level accepted after two equal consecutive slow samples.
module otc_top #(
    parameter SLOW_LOG2 = `OTC_SLOW_LOG2
) (
    input wire clock,
    input wire resetn,
    input wire [`OTC_AW-1:0] reg_addr,
    input wire [`OTC_DW-1:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [`OTC_DW-1:0] reg_rdata,
    input wire chipselect_switch_pin,
    input wire overtemp_flag,
    output reg speaker_pos_enable,
    output reg speaker_neg_enable,
    output reg mono_enable,
    output reg speaker_pos_pin_boost,
    output reg speaker_neg_pin_boost,
    output reg mono_pin_boost,
    output reg tieoff_high_resistance,
    output reg unused_pin_buffer_power,
    output reg mono_pin_dc_drive,
    output wire irq
);
    reg [`OTC_DW-1:0] tieoff_q;
    reg [`OTC_DW-1:0] outen_q;
    reg [`OTC_DW-1:0] boost_q;
    reg [`OTC_DW-1:0] switch_q;
    reg [`OTC_IRQ_W-1:0] status_q;
    reg [`OTC_IRQ_W-1:0] mask_q;
    reg pin_meta_q;
    reg pin_sync_q;
    reg temp_meta_q;
    reg temp_sync_q;
    reg temp_prev_q;
    reg [`OTC_DW-1:0] rdata_d;
    reg [`OTC_IRQ_W-1:0] status_d;

    wire tieoff_resistance_select = tieoff_q[`OTC_F_RES_SEL];
    wire overtemp_shutdown_enable = tieoff_q[`OTC_F_TSD_EN];
    wire speaker_pos_en_bit = outen_q[`OTC_F_SPKP_EN];
    wire speaker_neg_en_bit = outen_q[`OTC_F_SPKN_EN];
    wire mono_output_enable = outen_q[`OTC_F_MONO_EN];
    wire unused_pin_buffer_enable = outen_q[`OTC_F_BUF_EN];
    wire mono_dc_reference_mode = outen_q[`OTC_F_MONO_MUTE];
    wire speaker_level_shift_select = boost_q[`OTC_F_SPK_BOOST];
    wire mono_level_shift_select = boost_q[`OTC_F_MONO_BOOST];
    wire [`OTC_PINSEL_W-1:0] shared_pin_function_select =
        switch_q[`OTC_F_PINSEL_LO +: `OTC_PINSEL_W];
    wire switch_input_polarity = switch_q[`OTC_F_SW_POL];
    wire slow_tick_enable = switch_q[`OTC_F_SLOW_EN];
    wire two_wire_mode = switch_q[`OTC_F_TWO_WIRE];

    wire switch_mode;
    wire slow_tick;
    wire switch_stable;
    wire switch_changed;
    wire switch_level;
    wire speaker_allowed;
    wire mono_allowed;
    wire tsd_active;
    wire tsd_event;

    // Pin and temperature inputs are asynchronous to the master clock
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
            temp_meta_q <= 1'b0;
            temp_sync_q <= 1'b0;
            temp_prev_q <= 1'b0;
        end else begin
            pin_meta_q <= chipselect_switch_pin;
            pin_sync_q <= pin_meta_q;
            temp_meta_q <= overtemp_flag;
            temp_sync_q <= temp_meta_q;
            temp_prev_q <= temp_sync_q;
        end
    end

    assign switch_mode = two_wire_mode &&
        (shared_pin_function_select == `OTC_PINSEL_SWITCH); // see RQ6

    // Polarity applied before debounce so the filtered level is the selector
    assign switch_level = pin_sync_q ^ switch_input_polarity; // see RQ8

    otc_slow_tick #(
        .LOG2(SLOW_LOG2)
    ) u_tick (
        .clock(clock),
        .resetn(resetn),
        .enable(slow_tick_enable && switch_mode), // see RQ10
        .tick(slow_tick)
    );

    otc_debounce u_debounce (
        .clock(clock),
        .resetn(resetn),
        .tick(slow_tick),
        .level(switch_level),
        .stable(switch_stable),
        .changed(switch_changed)
    );

    // Outside switch mode the enable bits pass straight through
    assign speaker_allowed = !switch_mode || switch_stable; // see RQ7
    assign mono_allowed = !switch_mode || !switch_stable; // see RQ7

    assign tsd_active = temp_sync_q && overtemp_shutdown_enable; // see RQ11
    assign tsd_event = temp_sync_q && !temp_prev_q && overtemp_shutdown_enable;

    // Registered drive controls for the analogue output stages
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            speaker_pos_enable <= 1'b0;
            speaker_neg_enable <= 1'b0;
            mono_enable <= 1'b0;
            speaker_pos_pin_boost <= 1'b0;
            speaker_neg_pin_boost <= 1'b0;
            mono_pin_boost <= 1'b0;
            tieoff_high_resistance <= 1'b0;
            unused_pin_buffer_power <= 1'b0;
            mono_pin_dc_drive <= 1'b0;
        end else begin
            speaker_pos_enable <= speaker_pos_en_bit && speaker_allowed &&
                !tsd_active; // see RQ11
            speaker_neg_enable <= speaker_neg_en_bit && speaker_allowed &&
                !tsd_active; // see RQ11
            mono_enable <= mono_output_enable && mono_allowed; // see RQ7
            // Boost picks the reference both when enabled and when tied off
            speaker_pos_pin_boost <= speaker_level_shift_select; // see RQ3 see RQ4
            speaker_neg_pin_boost <= speaker_level_shift_select; // see RQ3 see RQ4
            mono_pin_boost <= mono_dc_reference_mode ? speaker_level_shift_select
                : mono_level_shift_select; // see RQ14
            tieoff_high_resistance <= tieoff_resistance_select; // see RQ1
            unused_pin_buffer_power <= unused_pin_buffer_enable; // see RQ5
            mono_pin_dc_drive <= mono_dc_reference_mode; // see RQ14
        end
    end

    // Register writes
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tieoff_q <= `OTC_TIEOFF_RESET; // see RQ2 see RQ12
            outen_q <= `OTC_OUTEN_RESET;
            boost_q <= `OTC_BOOST_RESET;
            switch_q <= `OTC_SWITCH_RESET;
            mask_q <= `OTC_IRQ_RESET;
        end else if (reg_write) begin
            case (reg_addr)
                `OTC_ADDR_TIEOFF: begin
                    tieoff_q <= reg_wdata;
                end
                `OTC_ADDR_OUTEN: begin
                    outen_q <= reg_wdata;
                end
                `OTC_ADDR_BOOST: begin
                    boost_q <= reg_wdata;
                end
                `OTC_ADDR_SWITCH: begin
                    switch_q <= reg_wdata;
                end
                `OTC_ADDR_IRQ_MASK: begin
                    mask_q <= reg_wdata[`OTC_IRQ_W-1:0];
                end
                default: begin
                    mask_q <= mask_q;
                end
            endcase
        end
    end

    // Sticky status: write one clears, a new event in the same cycle wins
    always @* begin
        status_d = status_q;
        if (reg_write && (reg_addr == `OTC_ADDR_IRQ_STATUS)) begin
            status_d = status_q & ~reg_wdata[`OTC_IRQ_W-1:0];
        end
        if (tsd_event) begin
            status_d[`OTC_I_TSD] = 1'b1; // see RQ13
        end
        if (switch_changed && switch_mode) begin
            status_d[`OTC_I_SWITCH] = 1'b1;
        end
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_q <= `OTC_IRQ_RESET;
        end else begin
            status_q <= status_d;
        end
    end

    assign irq = |(status_q & mask_q); // see RQ13

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_d = {`OTC_DW{1'b0}};
        case (reg_addr)
            `OTC_ADDR_TIEOFF: begin
                rdata_d = tieoff_q;
            end
            `OTC_ADDR_OUTEN: begin
                rdata_d = outen_q;
            end
            `OTC_ADDR_BOOST: begin
                rdata_d = boost_q;
            end
            `OTC_ADDR_SWITCH: begin
                rdata_d = switch_q;
            end
            `OTC_ADDR_IRQ_STATUS: begin
                rdata_d[`OTC_IRQ_W-1:0] = status_q;
            end
            `OTC_ADDR_IRQ_MASK: begin
                rdata_d[`OTC_IRQ_W-1:0] = mask_q;
            end
            `OTC_ADDR_STATE: begin
                rdata_d[0] = switch_stable;
                rdata_d[1] = temp_sync_q;
                rdata_d[2] = speaker_pos_enable;
                rdata_d[3] = speaker_neg_enable;
                rdata_d[4] = mono_enable;
                rdata_d[5] = switch_mode;
            end
            default: begin
                rdata_d = {`OTC_DW{1'b0}};
            end
        endcase
    end

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= {`OTC_DW{1'b0}};
        end else if (reg_read) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= {`OTC_DW{1'b0}};
        end
    end
endmodule
`default_nettype wire

// [sim/otc_jack_model.sv]
// Bouncing jack switch contact that drives the shared switch pin
`timescale 1ns/10ps
`default_nettype none
module otc_jack_model (
    input wire logic clock,
    input wire logic plugged,
    output logic pin
);
    logic last = 1'b0;
    int seed = 25780;
    initial pin = 1'b0;
    // Contact chatters for six cycles before it settles, less than one slow tick apart
    always @(posedge clock) begin
        if (plugged !== last) begin
            repeat (6) begin
                pin <= $random(seed);
                @(posedge clock);
            end
            pin <= plugged;
            last = plugged;
        end
    end
endmodule
`default_nettype wire

// [sim/otc_checker.sv]
// Concurrent checks on the tie-off, switch and thermal control ports
`timescale 1ns/10ps
`default_nettype none
module otc_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [6:0] reg_addr,
    input wire logic [8:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [8:0] reg_rdata,
    input wire logic overtemp_flag,
    input wire logic speaker_pos_enable,
    input wire logic speaker_neg_enable,
    input wire logic mono_enable,
    input wire logic speaker_pos_pin_boost,
    input wire logic mono_pin_boost,
    input wire logic tieoff_high_resistance,
    input wire logic unused_pin_buffer_power,
    input wire logic mono_pin_dc_drive,
    input wire logic irq
);
    // Shadows rebuilt from the write port, so outputs are judged against software intent
    logic [1:0] tie_sh;
    logic [4:0] oe_sh;
    logic [1:0] bst_sh;
    logic [5:0] sw_sh;
    logic msk_sh;
    logic swm;
    assign swm = sw_sh[5] && sw_sh[2:0] == 3'h1;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tie_sh <= 2'h2;
            oe_sh <= 5'h00;
            bst_sh <= 2'h0;
            sw_sh <= 6'h00;
            msk_sh <= 1'b0;
        end else if (reg_write) begin
            case (reg_addr)
                7'h31: tie_sh <= reg_wdata[1:0];
                7'h40: oe_sh <= reg_wdata[4:0];
                7'h41: bst_sh <= reg_wdata[1:0];
                7'h42: sw_sh <= reg_wdata[5:0];
                7'h44: msk_sh <= reg_wdata[0];
                default: ;
            endcase
        end
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (!resetn);
    property p_rd_tie; $past(reg_read) && $past(reg_addr) == 7'h31 |-> reg_rdata[1:0] == $past(tie_sh); endproperty
    a_rd_tie: assert property (p_rd_tie) else $error("tie-off readback wrong");
    property p_res; tieoff_high_resistance == $past(tie_sh[0]); endproperty
    a_res: assert property (p_res) else $error("tie-off resistance wrong");
    property p_spk_lvl; speaker_pos_pin_boost == $past(bst_sh[0]); endproperty
    a_spk_lvl: assert property (p_spk_lvl) else $error("speaker level wrong");
    property p_mono_lvl; mono_pin_boost == ($past(oe_sh[4]) ? $past(bst_sh[0]) : $past(bst_sh[1])); endproperty
    a_mono_lvl: assert property (p_mono_lvl) else $error("mono level wrong");
    property p_buf; unused_pin_buffer_power == $past(oe_sh[3]); endproperty
    a_buf: assert property (p_buf) else $error("tie-off buffer power wrong");
    property p_dc; mono_pin_dc_drive == $past(oe_sh[4]); endproperty
    a_dc: assert property (p_dc) else $error("mono dc drive wrong");
    property p_gate; !(speaker_pos_enable && !$past(oe_sh[0])) && !(mono_enable && !$past(oe_sh[2])); endproperty
    a_gate: assert property (p_gate) else $error("output on without its enable");
    property p_excl; swm && $past(swm) |-> !(speaker_pos_enable && mono_enable); endproperty
    a_excl: assert property (p_excl) else $error("speaker and mono both on");
    property p_tsd; (overtemp_flag && tie_sh[1]) [*4] |-> !speaker_pos_enable && !speaker_neg_enable; endproperty
    a_tsd: assert property (p_tsd) else $error("speaker on while overheated");
    property p_irq; $rose(overtemp_flag) && tie_sh[1] && msk_sh |-> ##[2:8] irq; endproperty
    a_irq: assert property (p_irq) else $error("thermal interrupt missing");
    c_spk: cover property (swm && speaker_pos_enable);
    c_mono: cover property (swm && mono_enable);
    c_irq: cover property ($rose(irq));
endmodule
bind otc_top otc_checker u_chk (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .overtemp_flag, .speaker_pos_enable, .speaker_neg_enable, .mono_enable,
    .speaker_pos_pin_boost, .mono_pin_boost, .tieoff_high_resistance, .unused_pin_buffer_power,
    .mono_pin_dc_drive, .irq);
`default_nettype wire

// [sim/tb_otc_top.sv]
// Self-checking bench for the output tie-off, switch and thermal control block
`timescale 1ns/10ps
`default_nettype none
module tb_otc_top;
    logic clock, resetn, reg_write, reg_read, plugged, overtemp_flag, pin;
    logic rd_pend = 1'b0;
    logic [6:0] reg_addr;
    logic [8:0] reg_wdata, reg_rdata, v, exp_q[$];
    wire logic [8:0] outs;
    wire logic spe, sne, me, spb, snb, mb, thr, ubp, mdc, irq;
    int errors = 0, n_checks = 0, seed = 25780;
    assign outs = {spe, sne, me, spb, snb, mb, thr, ubp, mdc};
    otc_top #(.SLOW_LOG2(3)) DUT (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .chipselect_switch_pin(pin), .overtemp_flag(overtemp_flag), .speaker_pos_enable(spe),
        .speaker_neg_enable(sne), .mono_enable(me), .speaker_pos_pin_boost(spb),
        .speaker_neg_pin_boost(snb), .mono_pin_boost(mb), .tieoff_high_resistance(thr),
        .unused_pin_buffer_power(ubp), .mono_pin_dc_drive(mdc), .irq(irq));
    otc_jack_model jack (.clock(clock), .plugged(plugged), .pin(pin));
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [8:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic po(input logic [8:0] e);
        @(negedge clock);
        chk(outs, e);
        @(posedge clock);
    endtask
    task automatic ci(input logic e);
        @(negedge clock);
        chk({8'h00, irq}, {8'h00, e});
        @(posedge clock);
    endtask
    task final_report;
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Read data stands only in the cycle after the strobe, so it is taken mid-cycle
    always @(posedge clock) rd_pend <= reg_read;
    always @(negedge clock) if (rd_pend) chk(reg_rdata, exp_q.pop_front());
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        final_report;
    end
    initial begin
        resetn = 1'b0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 9'h000;
        plugged = 1'b0;
        overtemp_flag = 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        wr(7'h7F, 9'h1FF);
        rd(7'h31, 9'h002);
        rd(7'h7F, 9'h000);
        repeat (8) begin
            v = $random(seed);
            wr(7'h31, {7'h01, v[5]});
            wr(7'h40, {4'h0, v[4:0]});
            wr(7'h41, {7'h00, v[8:7]});
            rd(7'h40, {4'h0, v[4:0]});
            po({v[0], v[1], v[2], v[7], v[7], v[4] ? v[7] : v[8], v[5], v[3], v[4]});
        end
        wr(7'h31, 9'h002);
        wr(7'h40, 9'h007);
        wr(7'h41, 9'h000);
        wr(7'h44, 9'h003);
        for (int p = 0; p < 2; p++) begin
            wr(7'h42, p ? 9'h039 : 9'h031);
            for (int k = 0; k < 2; k++) begin
                plugged <= k[0];
                repeat (80) @(posedge clock);
                v[0] = k[0] ^ p[0];
                po({v[0], v[0], !v[0], 6'h00});
            end
        end
        wr(7'h42, 9'h021);
        // Level now asks for the speaker, but with no slow tick the mono choice must hold
        plugged <= 1'b1;
        repeat (80) @(posedge clock);
        po(9'h040);
        wr(7'h42, 9'h022);
        po(9'h1C0);
        wr(7'h42, 9'h000);
        wr(7'h43, 9'h003);
        rd(7'h43, 9'h000);
        overtemp_flag <= 1'b1;
        repeat (10) @(posedge clock);
        po(9'h040);
        ci(1'b1);
        rd(7'h43, 9'h001);
        wr(7'h44, 9'h000);
        ci(1'b0);
        wr(7'h43, 9'h001);
        wr(7'h44, 9'h003);
        overtemp_flag <= 1'b0;
        wr(7'h31, 9'h000);
        overtemp_flag <= 1'b1;
        repeat (10) @(posedge clock);
        po(9'h1C0);
        ci(1'b0);
        final_report;
    end
endmodule
`default_nettype wire
